//--- hdl/pcg_pin.sv
// one pin of the port: chooses what drives it and whether its pull-up is on
module pcg_pin (
   input wire logic mode7_i,
   input wire logic dir_i,
   input wire logic data_i,
   input wire logic addr_i,
   input wire logic pcr_i,
   input wire logic stby_i,
   output logic drive_val_o,
   output logic drive_en_o,
   output logic pullup_o
);

   // standby releases the pin and kills the pull-up before anything else
   always_comb begin
      drive_val_o = 1'b0;
      drive_en_o = 1'b0;
      pullup_o = 1'b0;
      if (stby_i) begin
         pullup_o = 1'b0;
      end else if (dir_i) begin
         drive_en_o = 1'b1;
         // mode 7 drives the data register, mode 6 the address bit
         drive_val_o = mode7_i ? data_i : addr_i;
         pullup_o = 1'b0;
      end else begin
         // input role in either mode, pull-up purely software controlled
         pullup_o = pcr_i;
      end
   end

endmodule

//--- hdl/pcg_top.sv
// Chosen here: the placing of the registers and the AXI4-Lite slave port.

`include "pcg_map.svh"

module pcg_top
   import pcg_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic MODE7_SEL_I,
   input wire logic HW_STBY_N_I,
   input wire logic [`PCG_PORT_W-1:0] EXT_ADDR_I,
   input wire logic [`PCG_PORT_W-1:0] PORT_PIN_I,
   output logic [`PCG_PORT_W-1:0] PORT_PIN_O,
   output logic [`PCG_PORT_W-1:0] PORT_PIN_OE_N_O,
   output logic [`PCG_PORT_W-1:0] PORT_PULLUP_EN_O,
   input wire logic [`PCG_ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [`PCG_ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);

   // every register comes out of reset in a defined state, pins released
   localparam pcg_state_s PCG_RST_S = '{
      // register file
      dir: `PCG_DIR_RST,
      odr: `PCG_ODR_RST,
      pcr: `PCG_PCR_RST,
      // synchronisers and the mode strap
      pin_meta: 8'h00,
      pin_sync: 8'h00,
      stby_meta: 1'b0,
      stby_sync: 1'b0,
      mode_meta: 1'b0,
      mode_sync: 1'b0,
      mode7: 1'b0,
      mode_wait: 2'h0,
      // write channel
      wr_st: WR_IDLE,
      aw_have: 1'b0,
      w_have: 1'b0,
      aw_addr: 8'h00,
      w_data: 8'h00,
      w_lane0: 1'b0,
      awready: 1'b0,
      wready: 1'b0,
      bvalid: 1'b0,
      bresp: `PCG_RESP_OKAY,
      // read channel
      rd_st: RD_IDLE,
      arready: 1'b0,
      rvalid: 1'b0,
      rresp: `PCG_RESP_OKAY,
      rdata: 32'h0000_0000,
      // pads released: no drive, no pull-up
      pin_o: 8'h00,
      oe_n: `PCG_OE_N_RST,
      pu: 8'h00
   };

   // reset synchroniser, outside the state struct because it resets on the raw pin
   logic rst_meta_n;
   logic rst_sync_n;

   // whole-block state and its next value
   pcg_state_s s_reg;
   pcg_state_s s_next;

   // per-pin results of the function select and of the readback mux
   pcg_byte_t drv_val;
   pcg_byte_t drv_en;
   pcg_byte_t pu_req;
   pcg_byte_t pin_rd;

   // mode freeze and bus decode
   logic mode_frozen;
   pcg_sel_e wr_sel;
   pcg_sel_e rd_sel;

   // write channel handshake helpers
   logic aw_fire;
   logic w_fire;
   logic aw_got;
   logic w_got;
   logic [`PCG_ADDR_W-1:0] wr_addr;
   pcg_byte_t wr_data;
   logic wr_lane0;

   // address decode shared by the write and the read path
   // unmapped offsets fall through to none and are answered with an error
   function automatic pcg_sel_e reg_decode(input logic [`PCG_ADDR_W-1:0] addr);
      pcg_sel_e sel;
      sel = SEL_NONE;
      if (addr == `PCG_DIR_OFS) begin
         sel = SEL_DIR;
      end else if (addr == `PCG_ODR_OFS) begin
         sel = SEL_ODR;
      end else if (addr == `PCG_PIN_OFS) begin
         sel = SEL_PIN;
      end else if (addr == `PCG_PCR_OFS) begin
         sel = SEL_PCR;
      end else if (addr == `PCG_STAT_OFS) begin
         sel = SEL_STAT;
      end
      return sel;
   endfunction

   // reset release is synchronised; assertion stays asynchronous
   // the raw pin reaches only these two flops; all else resets on the released copy
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // per-pin function select, one copy per bit
   // the address byte goes straight through: it comes from logic on this clock
   genvar gi;
   generate
      for (gi = 0; gi < `PCG_PORT_W; gi++) begin : g_pin
         pcg_pin u_pin (
            .mode7_i(s_reg.mode7),
            .dir_i(s_reg.dir[gi]),
            .data_i(s_reg.odr[gi]),
            .addr_i(EXT_ADDR_I[gi]),
            .pcr_i(s_reg.pcr[gi]),
            .stby_i(s_reg.stby_sync),
            .drive_val_o(drv_val[gi]),
            .drive_en_o(drv_en[gi]),
            .pullup_o(pu_req[gi])
         );
      end
   endgenerate

   // pin state readback, one mux per bit; a loaded output still reads what was written
   generate
      for (gi = 0; gi < `PCG_PORT_W; gi++) begin : g_rd
         assign pin_rd[gi] = s_reg.dir[gi] ? s_reg.odr[gi] : s_reg.pin_sync[gi];
      end
   endgenerate

   // handshakes seen this cycle; address and data may arrive in either order
   // a half taken early is held in the state until its partner arrives
   assign aw_fire = S_AXI_AWVALID_I & s_reg.awready;
   assign w_fire = S_AXI_WVALID_I & s_reg.wready;
   assign aw_got = s_reg.aw_have | aw_fire;
   assign w_got = s_reg.w_have | w_fire;
   assign wr_addr = aw_fire ? S_AXI_AWADDR_I : s_reg.aw_addr;
   assign wr_data = w_fire ? S_AXI_WDATA_I[7:0] : s_reg.w_data;
   assign wr_lane0 = w_fire ? S_AXI_WSTRB_I[0] : s_reg.w_lane0;
   assign wr_sel = reg_decode(wr_addr);
   assign rd_sel = reg_decode(S_AXI_ARADDR_I);
   // the strap is trusted only once its synchroniser has settled
   assign mode_frozen = (s_reg.mode_wait == `PCG_MODE_SETTLE);

   // next-state logic for the whole block
   always_comb begin
      // every field holds by default, so each branch names only what changes
      s_next = s_reg;

      // pins and straps come from outside the clock domain; only the second flop is read
      s_next.pin_meta = PORT_PIN_I;
      s_next.pin_sync = s_reg.pin_meta;
      s_next.stby_meta = ~HW_STBY_N_I;
      s_next.stby_sync = s_reg.stby_meta;
      s_next.mode_meta = MODE7_SEL_I;
      s_next.mode_sync = s_reg.mode_meta;

      // the mode strap is followed until the synchroniser has settled, then frozen;
      // a strap that moves later is ignored until the next reset
      if (!mode_frozen) begin
         s_next.mode_wait = s_reg.mode_wait + 2'h1;
         s_next.mode7 = s_reg.mode_sync;
      end

      // write channel: collect address and data, then one response
      case (s_reg.wr_st)
         WR_IDLE: begin
            s_next.aw_have = aw_got;
            s_next.w_have = w_got;
            if (aw_fire) begin
               s_next.aw_addr = S_AXI_AWADDR_I;
            end
            if (w_fire) begin
               s_next.w_data = S_AXI_WDATA_I[7:0];
               s_next.w_lane0 = S_AXI_WSTRB_I[0];
            end
            s_next.awready = ~aw_got;
            s_next.wready = ~w_got;
            // both halves held: the register and the answer both change on the next edge
            if (aw_got && w_got) begin
               s_next.bvalid = 1'b1;
               s_next.bresp = `PCG_RESP_OKAY;
               s_next.awready = 1'b0;
               s_next.wready = 1'b0;
               s_next.wr_st = WR_RESP;
               // only byte lane 0 carries register bits; upper lanes are ignored
               if (wr_sel == SEL_DIR) begin
                  if (wr_lane0) begin
                     s_next.dir = wr_data;
                  end
               end else if (wr_sel == SEL_ODR) begin
                  if (wr_lane0) begin
                     s_next.odr = wr_data;
                  end
               end else if (wr_sel == SEL_PCR) begin
                  if (wr_lane0) begin
                     s_next.pcr = wr_data;
                  end
               end else if (wr_sel == SEL_PIN) begin
                  // accepted and dropped so software sees no fault
                  s_next.bresp = `PCG_RESP_OKAY;
               end else if (wr_sel == SEL_STAT) begin
                  // status is read-only as well; the write is dropped the same way
                  s_next.bresp = `PCG_RESP_OKAY;
               end else begin
                  s_next.bresp = `PCG_RESP_SLVERR;
               end
            end
         end
         WR_RESP: begin
            // the readies come back only here, so a second write cannot overtake the answer
            if (S_AXI_BREADY_I) begin
               s_next.bvalid = 1'b0;
               s_next.aw_have = 1'b0;
               s_next.w_have = 1'b0;
               s_next.awready = 1'b1;
               s_next.wready = 1'b1;
               s_next.wr_st = WR_IDLE;
            end
         end
         default: begin
            // an unused encoding drops back to idle instead of locking the channel
            s_next.wr_st = WR_IDLE;
         end
      endcase

      // read channel: one address, one data beat, no overlap
      case (s_reg.rd_st)
         RD_IDLE: begin
            s_next.arready = 1'b1;
            if (S_AXI_ARVALID_I && s_reg.arready) begin
               s_next.arready = 1'b0;
               s_next.rvalid = 1'b1;
               s_next.rresp = `PCG_RESP_OKAY;
               // upper bits and unused fields read as zero
               s_next.rdata = 32'h0000_0000;
               s_next.rd_st = RD_DATA;
               if (rd_sel == SEL_DIR) begin
                  // write-only: a read returns zero rather than the setting
                  s_next.rdata = 32'h0000_0000;
               end else if (rd_sel == SEL_ODR) begin
                  s_next.rdata[7:0] = s_reg.odr;
               end else if (rd_sel == SEL_PIN) begin
                  // outputs read back the latch, inputs the synchronised pin
                  s_next.rdata[7:0] = pin_rd;
               end else if (rd_sel == SEL_PCR) begin
                  s_next.rdata[7:0] = s_reg.pcr;
               end else if (rd_sel == SEL_STAT) begin
                  s_next.rdata[`PCG_STAT_MODE7_BIT] = s_reg.mode7;
                  s_next.rdata[`PCG_STAT_STBY_BIT] = s_reg.stby_sync;
               end else begin
                  // unmapped offsets answer zero data with an error
                  s_next.rresp = `PCG_RESP_SLVERR;
               end
            end
         end
         RD_DATA: begin
            // the address ready returns only once the data beat is taken
            if (S_AXI_RREADY_I) begin
               s_next.rvalid = 1'b0;
               s_next.arready = 1'b1;
               s_next.rd_st = RD_IDLE;
            end
         end
         default: begin
            // an unused encoding drops back to idle instead of locking the channel
            s_next.rd_st = RD_IDLE;
         end
      endcase

      // pin drivers registered so the pads see clean edges
      // one clock from a register write to the pad, the same in both modes
      s_next.pin_o = drv_val;
      s_next.oe_n = ~drv_en;
      s_next.pu = pu_req;
   end

   // single state register; reset forces pull-ups off and pins released
   // no clock enable: every field moves on every edge, holding is done in s_next
   always_ff @(posedge CORE_CLK_I or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_reg <= PCG_RST_S;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register
   assign PORT_PIN_O = s_reg.pin_o;
   assign PORT_PIN_OE_N_O = s_reg.oe_n;
   assign PORT_PULLUP_EN_O = s_reg.pu;

   // bus handshakes and answers, also straight from flops
   assign S_AXI_AWREADY_O = s_reg.awready;
   assign S_AXI_WREADY_O = s_reg.wready;
   assign S_AXI_BRESP_O = s_reg.bresp;
   assign S_AXI_BVALID_O = s_reg.bvalid;
   assign S_AXI_ARREADY_O = s_reg.arready;
   assign S_AXI_RDATA_O = s_reg.rdata;
   assign S_AXI_RRESP_O = s_reg.rresp;
   assign S_AXI_RVALID_O = s_reg.rvalid;

endmodule

//--- include/pcg_map.svh
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// port geometry
`define PCG_PORT_W 8
`define PCG_ADDR_W 8

// register byte offsets on the AXI4-Lite slave
`define PCG_DIR_OFS 8'h00
`define PCG_ODR_OFS 8'h04
`define PCG_PIN_OFS 8'h08
`define PCG_PCR_OFS 8'h0C
`define PCG_STAT_OFS 8'h10

// reset values
`define PCG_DIR_RST 8'h00
`define PCG_ODR_RST 8'h00
`define PCG_PCR_RST 8'h00
`define PCG_OE_N_RST 8'hFF

// status register field positions
`define PCG_STAT_MODE7_BIT 0
`define PCG_STAT_STBY_BIT 1

// cycles after reset release before the mode strap is frozen
`define PCG_MODE_SETTLE 2'h3

// AXI responses
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2

`endif

//--- include/pcg_pkg.sv
`include "pcg_map.svh"

package pcg_pkg;

   typedef enum logic [0:0] {WR_IDLE, WR_RESP} pcg_wr_e;
   typedef enum logic [0:0] {RD_IDLE, RD_DATA} pcg_rd_e;
   typedef enum logic [2:0] {SEL_NONE, SEL_DIR, SEL_ODR, SEL_PIN, SEL_PCR, SEL_STAT} pcg_sel_e;

   typedef logic [`PCG_PORT_W-1:0] pcg_byte_t;

   typedef struct packed {
      pcg_byte_t dir;
      pcg_byte_t odr;
      pcg_byte_t pcr;
      pcg_byte_t pin_meta;
      pcg_byte_t pin_sync;
      logic stby_meta;
      logic stby_sync;
      logic mode_meta;
      logic mode_sync;
      logic mode7;
      logic [1:0] mode_wait;
      pcg_wr_e wr_st;
      logic aw_have;
      logic w_have;
      logic [`PCG_ADDR_W-1:0] aw_addr;
      pcg_byte_t w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      pcg_rd_e rd_st;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      pcg_byte_t pin_o;
      pcg_byte_t oe_n;
      pcg_byte_t pu;
   } pcg_state_s;

endpackage

//--- verification/pcg_chk.sv
module pcg_chk (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic MODE7_SEL_I,
   input wire logic HW_STBY_N_I,
   input wire logic [7:0] EXT_ADDR_I,
   input wire logic [7:0] PORT_PIN_O,
   input wire logic [7:0] PORT_PIN_OE_N_O,
   input wire logic [7:0] PORT_PULLUP_EN_O,
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // pad ownership
   pull_off_a: assert property ((PORT_PULLUP_EN_O & ~PORT_PIN_OE_N_O) == 8'h00)
      else $error("pull-up on at a driven pin");
   stby_off_a: assert property (!HW_STBY_N_I [*4] |->
      PORT_PULLUP_EN_O == 8'h00 && PORT_PIN_OE_N_O == 8'hFF)
      else $error("standby left a pad active");
   addr_out_a: assert property (!MODE7_SEL_I |=>
      ((PORT_PIN_O ^ $past(EXT_ADDR_I)) & ~PORT_PIN_OE_N_O) == 8'h00)
      else $error("driven pad not showing address byte");
   // register bus handshakes
   wr_resp_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
      && S_AXI_WREADY_O |=> S_AXI_BVALID_O)
      else $error("no write response");
   b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
      S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped");
   ready_low_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
      else $error("write taken during response");
   r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
      S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O))
      else $error("read data dropped");
   rd_resp_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=>
      S_AXI_RVALID_O && S_AXI_RDATA_O[31:8] == 24'h00_0000)
      else $error("bad read answer");
   wr_c: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
   rd_c: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
   stby_c: cover property (!HW_STBY_N_I [*4]);
   addr_c: cover property (!MODE7_SEL_I && PORT_PIN_OE_N_O != 8'hFF);
endmodule
bind pcg_top pcg_chk u_chk (
   .CORE_CLK_I(CORE_CLK_I),
   .RST_N_I(RST_N_I),
   .MODE7_SEL_I(MODE7_SEL_I),
   .HW_STBY_N_I(HW_STBY_N_I),
   .EXT_ADDR_I(EXT_ADDR_I),
   .PORT_PIN_O(PORT_PIN_O),
   .PORT_PIN_OE_N_O(PORT_PIN_OE_N_O),
   .PORT_PULLUP_EN_O(PORT_PULLUP_EN_O),
   .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O),
   .S_AXI_BRESP_O(S_AXI_BRESP_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_BREADY_I(S_AXI_BREADY_I),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RDATA_O(S_AXI_RDATA_O),
   .S_AXI_RRESP_O(S_AXI_RRESP_O),
   .S_AXI_RVALID_O(S_AXI_RVALID_O),
   .S_AXI_RREADY_I(S_AXI_RREADY_I)
);

//--- verification/pcg_pads.sv
// pad model: resolves each pad from the core driver, an outside driver and the pull-up
module pcg_pads (
   input wire logic clk_i,
   input wire logic [7:0] pin_o_i,
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] pu_i,
   input wire logic [7:0] ext_i,
   input wire logic [7:0] ext_en_i,
   output logic [7:0] pad_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic tog = 1'b0;
   // a floating pad wanders every cycle so a missing pull-up never reads as a lucky level
   always @(posedge clk_i) tog <= ~tog;
   // core drive wins; otherwise outside driver, then pull-up, then float
   assign pad_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_en_i & ext_i)
                | (oe_n_i & ~ext_en_i & pu_i)
                | (oe_n_i & ~ext_en_i & ~pu_i & {8{tog}});
endmodule

//--- verification/port_c_gpio_address_pins_bench.sv
`include "pcg_map.svh"
module port_c_gpio_address_pins_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_n = 0, mode7 = 1, stby_n = 1;
   logic [7:0] ea = 0, awaddr = 0, araddr = 0, ext = 0, ext_en = 8'hFF;
   logic [7:0] pin_i, pin_o, oe_n, pu, dir, odr, pcr, x;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   integer seed = 32'h86fe;
   int bad_count = 0, n_compared = 0, cyc = 0;
   always #12.5 clk = ~clk;
   pcg_top u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .MODE7_SEL_I(mode7),
      .HW_STBY_N_I(stby_n), .EXT_ADDR_I(ea), .PORT_PIN_I(pin_i), .PORT_PIN_O(pin_o),
      .PORT_PIN_OE_N_O(oe_n), .PORT_PULLUP_EN_O(pu), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready));
   pcg_pads u_pads (.clk_i(clk), .pin_o_i(pin_o), .oe_n_i(oe_n), .pu_i(pu), .ext_i(ext),
      .ext_en_i(ext_en), .pad_o(pin_i));
   task automatic finish_test();
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // pin state seen by software: own data where driving, pad level elsewhere
   function automatic logic [7:0] pin_exp(input logic [7:0] dr, od, pc, xv);
      return (dr & od) | (~dr & (pc | xv));
   endfunction
   // status word: latched mode in one bit, standby in another, the rest zero
   function automatic logic [31:0] stat_exp(input logic m7, sb);
      stat_exp = 32'h0000_0000;
      stat_exp[`PCG_STAT_MODE7_BIT] = m7;
      stat_exp[`PCG_STAT_STBY_BIT] = sb;
   endfunction
   // ready is raised only once the answer shows, so the slave must hold it a cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s,
      input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= dv;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) begin
            bready <= 1'b0;
            chk(bresp, er);
            break;
         end
         if (bvalid) bready <= 1'b1;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) begin
            rready <= 1'b0;
            chk(rdata, exp);
            chk(rresp, er);
            break;
         end
         if (rvalid) rready <= 1'b1;
      end
   endtask
   // mode strap only moves while reset is held
   task automatic go(input logic m);
      @(posedge clk);
      rst_n <= 1'b0;
      mode7 <= m;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // random settings with the all-in and all-out corners first
   task automatic sweep();
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : $random(seed);
         dir = d[7:0];
         odr = $random(seed);
         pcr = $random(seed);
         x = $random(seed);
         @(posedge clk);
         ext <= x;
         ext_en <= ~pcr;
         ea <= $random(seed);
         wr(`PCG_DIR_OFS, d, 4'hF, 2'h0);
         wr(`PCG_ODR_OFS, {24'($random(seed)), odr}, 4'hF, 2'h0);
         wr(`PCG_PCR_OFS, {24'h00_0000, pcr}, 4'hF, 2'h0);
         repeat (3) @(posedge clk);
         chk(oe_n, 8'(~dir));
         chk(pu, 8'(~dir & pcr));
         chk(pin_o & dir, (mode7 ? odr : ea) & dir);
         rd(`PCG_PIN_OFS, pin_exp(dir, odr, pcr, x), 2'h0);
         rd(`PCG_ODR_OFS, odr, 2'h0);
         rd(`PCG_PCR_OFS, pcr, 2'h0);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      go(1'b1);
      chk(oe_n, 8'hFF);
      chk(pu, 8'h00);
      rd(`PCG_ODR_OFS, 0, 2'h0);
      rd(`PCG_PCR_OFS, 0, 2'h0);
      $display("test reset done");
      sweep();
      $display("test mode7 done");
      wr(`PCG_PIN_OFS, 32'hFFFF_FFFF, 4'hF, 2'h0);
      wr(`PCG_STAT_OFS, 32'hFFFF_FFFF, 4'hF, 2'h0);
      wr(8'h14, 32'hFFFF_FFFF, 4'hF, 2'h2);
      wr(`PCG_ODR_OFS, ~{24'h0, odr}, 4'hE, 2'h0);
      rd(8'h14, 0, 2'h2);
      rd(`PCG_ODR_OFS, odr, 2'h0);
      rd(`PCG_PIN_OFS, pin_exp(dir, odr, pcr, x), 2'h0);
      rd(`PCG_DIR_OFS, 0, 2'h0);
      $display("test refusal done");
      stby_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk(oe_n, 8'hFF);
      chk(pu, 8'h00);
      chk(pin_o, 8'h00);
      rd(`PCG_STAT_OFS, stat_exp(1'b1, 1'b1), 2'h0);
      stby_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(oe_n, 8'(~dir));
      chk(pu, 8'(~dir & pcr));
      chk(pin_o & dir, odr & dir);
      $display("test standby done");
      go(1'b0);
      sweep();
      rd(`PCG_STAT_OFS, stat_exp(1'b0, 1'b0), 2'h0);
      $display("test mode6 done");
      finish_test();
   end
endmodule
